// >>> rtl/linear11_encoder.sv
`timescale 1ns/1ps
`include "telemetry_cfg.svh"

module linear11_encoder (
	// Unsigned reading and exponent of its count weight
	input wire logic [13:0] count,
	input wire logic [4:0] base_exp,
	// Linear11 word
	output logic [15:0] word
);

	// ----------------------------------------
	// Smallest right shift that fits the mantissa
	// ----------------------------------------
	function automatic logic [2:0] fit_shift(input logic [13:0] value);
		logic [2:0] s;
		s = `MAX_SHIFT;
		for (int i = 4; i >= 0; i--) begin
			if ((value >> i) <= `MANT_MAX) begin
				s = 3'(i);
			end
		end
		return s;
	endfunction : fit_shift

	wire logic [2:0] shift = fit_shift(count);
	wire logic [13:0] shifted = count >> shift;
	wire logic [4:0] exponent = base_exp + {2'h0, shift};

	assign word = {exponent, shifted[`MANT_MSB:0]};

endmodule : linear11_encoder

// >>> rtl/telemetry_cfg.svh
`ifndef TELEMETRY_CFG_SVH
`define TELEMETRY_CFG_SVH

// ----------------------------------------
// Command codes of the telemetry words
// ----------------------------------------
`define CMD_INPUT_VOLTAGE 8'h88
`define CMD_OUTPUT_VOLTAGE 8'h8B
`define CMD_OUTPUT_CURRENT 8'h8C
`define CMD_TEMPERATURE 8'h8D

// ----------------------------------------
// Field layout
// ----------------------------------------
`define EXP_MSB 15
`define EXP_LSB 11
`define MANT_MSB 10
`define VOLT_DIRECT_MSB 10
`define CURR_DIRECT_MSB 13
`define TEMP_MSB 7

// ----------------------------------------
// Linear11 base exponents (count weight)
// ----------------------------------------
// 31.25 mV per count is 2^-5 V
`define VOLT_BASE_EXP 5'h1B
// 62.5 mA per count is 2^-4 A
`define CURR_BASE_EXP 5'h1C
// Largest positive 11-bit mantissa
`define MANT_MAX 14'h03FF
`define MAX_SHIFT 3'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define READ_DATA_RESET 16'h0000

`endif

// >>> rtl/telemetry_pkg.sv
package telemetry_pkg;

	// ----------------------------------------
	// Encoding selected by the format bit
	// ----------------------------------------
	typedef enum logic [0:0] {
		FMT_LINEAR = 1'b0,
		FMT_DIRECT = 1'b1
	} format_type;

	// ----------------------------------------
	// Which telemetry word a command selects
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_VIN = 3'b001,
		SEL_VOUT = 3'b010,
		SEL_IOUT = 3'b011,
		SEL_TEMP = 3'b100
	} reading_sel_type;

endpackage : telemetry_pkg

// >>> rtl/telemetry_readback_formatter.sv
`timescale 1ns/1ps
`include "telemetry_cfg.svh"


module telemetry_readback_formatter (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Converted readings
	input wire logic [10:0] vin_count,
	input wire logic [10:0] vout_count,
	input wire logic [13:0] iout_count,
	input wire logic [7:0] temp_sense_pin_reading,
	// Format select bit from the configuration register
	input wire logic direct_format_sel,
	// Read requests from the bus slave
	input wire logic rd_start,
	input wire logic [7:0] rd_cmd,
	// Write requests from the bus slave
	input wire logic wr_strobe,
	input wire logic [7:0] wr_cmd,
	// Read answer
	output logic [15:0] rd_data_ff,
	output logic rd_valid_ff,
	output logic rd_hit_ff,
	// Write answer
	output logic wr_reject_ff
);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	function automatic telemetry_pkg::reading_sel_type decode_cmd(input logic [7:0] cmd);
		case (cmd)
			`CMD_INPUT_VOLTAGE: decode_cmd = telemetry_pkg::SEL_VIN;
			`CMD_OUTPUT_VOLTAGE: decode_cmd = telemetry_pkg::SEL_VOUT;
			`CMD_OUTPUT_CURRENT: decode_cmd = telemetry_pkg::SEL_IOUT;
			`CMD_TEMPERATURE: decode_cmd = telemetry_pkg::SEL_TEMP;
			default: decode_cmd = telemetry_pkg::SEL_NONE;
		endcase
	endfunction : decode_cmd

	telemetry_pkg::reading_sel_type rd_sel;
	telemetry_pkg::reading_sel_type wr_sel;
	telemetry_pkg::format_type fmt;

	assign rd_sel = decode_cmd(rd_cmd);
	assign wr_sel = decode_cmd(wr_cmd);
	assign fmt = telemetry_pkg::format_type'(direct_format_sel);

	// ----------------------------------------
	// Linear11 encoders
	// ----------------------------------------
	wire logic [15:0] vin_lin;
	wire logic [15:0] vout_lin;
	wire logic [15:0] iout_lin;

	linear11_encoder vin_enc (
		.count({3'h0, vin_count}),
		.base_exp(`VOLT_BASE_EXP),
		.word(vin_lin)
	);

	linear11_encoder vout_enc (
		.count({3'h0, vout_count}),
		.base_exp(`VOLT_BASE_EXP),
		.word(vout_lin)
	);

	linear11_encoder iout_enc (
		.count(iout_count),
		.base_exp(`CURR_BASE_EXP),
		.word(iout_lin)
	);

	// ----------------------------------------
	// Direct words
	// ----------------------------------------
	wire logic [15:0] vin_dir = {5'h00, vin_count};
	wire logic [15:0] vout_dir = {5'h00, vout_count};
	wire logic [15:0] iout_dir = {2'h0, iout_count};
	wire logic [15:0] temp_word = {8'h00, temp_sense_pin_reading};

	// ----------------------------------------
	// Word selection
	// ----------------------------------------
	wire logic use_direct = (fmt == telemetry_pkg::FMT_DIRECT);
	wire logic [15:0] vin_word = use_direct ? vin_dir : vin_lin;
	wire logic [15:0] vout_word = use_direct ? vout_dir : vout_lin;
	wire logic [15:0] iout_word = use_direct ? iout_dir : iout_lin;

	logic [15:0] sel_word;
	always_comb begin
		case (rd_sel)
			telemetry_pkg::SEL_VIN: sel_word = vin_word;
			telemetry_pkg::SEL_VOUT: sel_word = vout_word;
			telemetry_pkg::SEL_IOUT: sel_word = iout_word;
			telemetry_pkg::SEL_TEMP: sel_word = temp_word;
			default: sel_word = `READ_DATA_RESET;
		endcase
	end

	wire logic rd_is_hit = (rd_sel != telemetry_pkg::SEL_NONE);
	wire logic wr_is_ours = wr_strobe && (wr_sel != telemetry_pkg::SEL_NONE);

	// ----------------------------------------
	// Snapshot and answer registers
	// ----------------------------------------
	wire logic [15:0] nxt_rd_data = rd_start ? sel_word : rd_data_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_data_ff <= `READ_DATA_RESET;
			rd_valid_ff <= 1'h0;
			rd_hit_ff <= 1'h0;
			wr_reject_ff <= 1'h0;
		end else begin
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= rd_start;
			rd_hit_ff <= rd_start ? rd_is_hit : rd_hit_ff;
			wr_reject_ff <= wr_is_ours;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	fmt_select_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_VOUT |=>
		rd_data_ff[15:11] == ($past(direct_format_sel) ? 5'h00 :
		($past(vout_count) > 11'h3FF ? 5'h1C : 5'h1B)))
		else $error("output voltage word ignores format bit");

	lin_exponent_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_VIN && !direct_format_sel |=>
		rd_data_ff[15:11] == ($past(vin_count) > 11'h3FF ? 5'h1C : 5'h1B))
		else $error("linear exponent wrong for input voltage");

	lin_mantissa_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_IOUT && !direct_format_sel |=>
		!rd_data_ff[10] &&
		(($past(iout_count) >> (rd_data_ff[15:11] - 5'h1C)) == {3'h0, rd_data_ff[10:0]}))
		else $error("linear mantissa does not match current reading");

	direct_volt_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_VIN && direct_format_sel |=>
		rd_data_ff == {5'h00, $past(vin_count)} && rd_valid_ff && rd_hit_ff)
		else $error("direct input voltage word wrong");

	direct_curr_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_IOUT && direct_format_sel |=>
		rd_data_ff == {2'h0, $past(iout_count)})
		else $error("direct output current word wrong");

	temp_direct_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_TEMP |=>
		rd_data_ff[7:0] == $past(temp_sense_pin_reading))
		else $error("temperature low byte wrong");

	temp_upper_a: assert property (
		(rd_start && rd_sel == telemetry_pkg::SEL_TEMP |=> rd_data_ff[15:8] == 8'h00) and
		(wr_strobe && wr_sel == telemetry_pkg::SEL_TEMP |=> wr_reject_ff &&
		($past(rd_start) || $stable(rd_data_ff))))
		else $error("temperature upper byte not zero or write taken");

	snapshot_hold_a: assert property (
		rd_valid_ff && !rd_start |=> !rd_valid_ff && $stable(rd_data_ff) && $stable(rd_hit_ff))
		else $error("snapshot changed without a new read");

	read_answer_a: assert property (
		rd_start |=> rd_valid_ff)
		else $error("read answer missing one cycle after start");

	unmapped_read_a: assert property (
		rd_start && !(rd_cmd inside {`CMD_INPUT_VOLTAGE, `CMD_OUTPUT_VOLTAGE,
		`CMD_OUTPUT_CURRENT, `CMD_TEMPERATURE}) |=> !rd_hit_ff && rd_data_ff == 16'h0000)
		else $error("unmapped read returned data");

	vout_mantissa_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_VOUT && !direct_format_sel |=>
		rd_data_ff[10:0] == ($past(vout_count) > 11'h3FF ? ($past(vout_count) >> 1) :
		$past(vout_count)))
		else $error("linear mantissa does not match output voltage");

	curr_exponent_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_IOUT && !direct_format_sel &&
		iout_count <= 14'h03FF |=> rd_data_ff[15:11] == 5'h1C)
		else $error("linear exponent wrong for small current");

	curr_full_scale_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_IOUT && !direct_format_sel &&
		iout_count == 14'h3FFF |=> rd_data_ff == 16'h03FF)
		else $error("full scale current word wrong");

	direct_vout_a: assert property (
		rd_start && rd_sel == telemetry_pkg::SEL_VOUT && direct_format_sel |=>
		rd_data_ff == {5'h00, $past(vout_count)})
		else $error("direct output voltage word wrong");

	write_reject_a: assert property (
		(wr_strobe && wr_sel != telemetry_pkg::SEL_NONE |=> wr_reject_ff) and
		(!wr_strobe |=> !wr_reject_ff))
		else $error("write reject pulse wrong");

	linear_read_c: cover property (
		rd_start && rd_sel == telemetry_pkg::SEL_IOUT && !direct_format_sel ##1 rd_valid_ff);
	direct_read_c: cover property (
		rd_start && rd_sel == telemetry_pkg::SEL_VOUT && direct_format_sel ##1 rd_valid_ff);
	temp_read_c: cover property (rd_start && rd_sel == telemetry_pkg::SEL_TEMP);
	unmapped_read_c: cover property (rd_start && !rd_is_hit ##1 rd_valid_ff && !rd_hit_ff);

endmodule : telemetry_readback_formatter

// >>> testbench/pmbus_host_model.sv
`timescale 1ns/1ps

module pmbus_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Read answer of the formatter
	input wire logic rd_valid,
	input wire logic [15:0] rd_data,
	// Bytes as the host receives them
	output logic [7:0] lo_byte,
	output logic [7:0] hi_byte
);
	// Both bytes are taken from the one held word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lo_byte <= 8'h00;
			hi_byte <= 8'h00;
		end else if (rd_valid) begin
			lo_byte <= rd_data[7:0];
			hi_byte <= rd_data[15:8];
		end
	end
endmodule : pmbus_host_model

// >>> testbench/telemetry_readback_formatter_bench.sv
`timescale 1ns/1ps
`include "telemetry_cfg.svh"
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
	$display("Error %0t: got %h expected %h", $time, got, exp); end end

module telemetry_readback_formatter_bench;
	logic clk, reset, direct_format_sel, rd_start, wr_strobe;
	logic [10:0] vin_count, vout_count;
	logic [13:0] iout_count;
	logic [7:0] temp_sense_pin_reading, rd_cmd, wr_cmd, lo_byte, hi_byte;
	logic [15:0] rd_data_ff, exp_data, host_exp;
	logic rd_valid_ff, rd_hit_ff, wr_reject_ff, exp_hit, exp_valid, exp_reject;
	logic [31:0] seed;
	logic [7:0] cmd_table [5];
	logic [15:0] host_q [$];
	int failures, checked, cycles;

	telemetry_readback_formatter dut (.clk(clk), .reset(reset), .vin_count(vin_count),
		.vout_count(vout_count), .iout_count(iout_count),
		.temp_sense_pin_reading(temp_sense_pin_reading), .direct_format_sel(direct_format_sel),
		.rd_start(rd_start), .rd_cmd(rd_cmd), .wr_strobe(wr_strobe), .wr_cmd(wr_cmd),
		.rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .rd_hit_ff(rd_hit_ff),
		.wr_reject_ff(wr_reject_ff));

	pmbus_host_model host (.clk(clk), .reset(reset), .rd_valid(rd_valid_ff),
		.rd_data(rd_data_ff), .lo_byte(lo_byte), .hi_byte(hi_byte));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
	endfunction : lfsr

	// Smallest shift that brings the count into the positive mantissa range
	function automatic logic [15:0] linear(input int count, input int base);
		int s;
		s = 0;
		while ((count >> s) > 1023)
			s++;
		return {5'(base + s), 11'(count >> s)};
	endfunction : linear

	function automatic logic [16:0] model(input logic [7:0] cmd, input logic fmt);
		case (cmd)
			`CMD_INPUT_VOLTAGE: return {1'b1, fmt ? {5'h00, vin_count} : linear(vin_count, -5)};
			`CMD_OUTPUT_VOLTAGE: return {1'b1, fmt ? {5'h00, vout_count} : linear(vout_count, -5)};
			`CMD_OUTPUT_CURRENT: return {1'b1, fmt ? {2'h0, iout_count} : linear(iout_count, -4)};
			`CMD_TEMPERATURE: return {1'b1, 8'h00, temp_sense_pin_reading};
			default: return 17'h00000;
		endcase
	endfunction : model

	task automatic end_of_test;
		if (failures == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		cmd_table = '{`CMD_INPUT_VOLTAGE, `CMD_OUTPUT_VOLTAGE, `CMD_OUTPUT_CURRENT,
			`CMD_TEMPERATURE, 8'h8A};
		{reset, direct_format_sel, rd_start, wr_strobe} = 4'hF;
		{vin_count, vout_count, iout_count, temp_sense_pin_reading} = 44'h0;
		{rd_cmd, wr_cmd} = 16'h0000;
		{exp_data, host_exp, exp_hit, exp_valid, exp_reject} = 35'h0;
		seed = 32'd89751;
		{failures, checked, cycles} = 0;
		rd_start = 1'b0;
		wr_strobe = 1'b0;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 600; i++) begin
			@(negedge clk);
			`CHECK(rd_valid_ff, exp_valid)
			`CHECK({rd_hit_ff, rd_data_ff}, {exp_hit, exp_data})
			`CHECK({hi_byte, lo_byte}, host_exp)
			`CHECK(wr_reject_ff, exp_reject)
			if (exp_valid) begin
				host_q.push_back(exp_data);
			end
			if (host_q.size() > 0) begin
				host_exp = host_q.pop_front();
			end
			seed = lfsr(seed);
			vin_count = seed[0] ? 11'h7FF : seed[11:1];
			vout_count = seed[12] ? 11'h3FF : seed[23:13];
			iout_count = seed[24] ? 14'h3FFF : {seed[31:25], seed[6:0]};
			temp_sense_pin_reading = seed[20:13];
			direct_format_sel = seed[5];
			rd_start = seed[9] | seed[3];
			rd_cmd = cmd_table[seed[30:28] % 5];
			wr_strobe = seed[17];
			wr_cmd = cmd_table[seed[27:25] % 5];
			exp_valid = rd_start;
			if (rd_start) begin
				{exp_hit, exp_data} = model(rd_cmd, direct_format_sel);
			end
			exp_reject = wr_strobe && wr_cmd != 8'h8A;
		end
		end_of_test();
	end
endmodule : telemetry_readback_formatter_bench
